/* design/rms_byte_reg.sv */
`timescale 1ns/1ns
module rms_byte_reg (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // write side
    input  wire logic       writeEn,
    input  wire logic [7:0] writeData,
    // stored value
    output logic      [7:0] value
);

    logic [7:0] value_reg;
    logic [7:0] value_next;

    assign value_next = writeEn ? writeData : value_reg;
    assign value      = value_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            value_reg <= rms_pkg::REG_RESET;
        end else begin
            value_reg <= value_next;
        end
    end

endmodule : rms_byte_reg

/* design/rms_pkg.sv */
package rms_pkg;

    // register addresses on the 5-bit control address
    localparam logic [4:0] CHIP_SETUP_ADDR    = 5'h00;
    localparam logic [4:0] SWITCH_SOURCE_ADDR = 5'h02;
    localparam logic [4:0] FIRST_MODE_ADDR    = 5'h06;
    localparam logic [4:0] SECOND_MODE_ADDR   = 5'h09;

    // register slots
    localparam int REG_COUNT       = 4;
    localparam int CHIP_SETUP_IDX  = 0;
    localparam int SWITCH_SRC_IDX  = 1;
    localparam int FIRST_MODE_IDX  = 2;
    localparam int SECOND_MODE_IDX = 3;

    // field positions
    localparam int MODE_SEL_BIT = 0;
    localparam int EXT_SEL_BIT  = 3;
    localparam int SUB_MSB      = 7;
    localparam int SUB_LSB      = 6;

    // values after reset
    localparam logic [7:0] REG_RESET  = 8'h00;
    localparam logic       MODE_RESET = 1'h0;
    localparam logic       SLEEP_RESET    = 1'h1;
    localparam logic       FLAG_RESET     = 1'h0;
    localparam logic       PIN_OUT_RESET  = 1'h0;
    localparam logic       PIN_OE_RESET   = 1'h1;
    localparam logic [7:0] RD_DATA_RESET  = 8'h00;
    localparam logic       RD_VALID_RESET = 1'h0;

    // sub-mode field encoding
    typedef enum logic [1:0] {
        SUB_SLEEP    = 2'h0,
        SUB_STANDBY  = 2'h1,
        SUB_RECEIVE  = 2'h2,
        SUB_TRANSMIT = 2'h3
    } rms_sub_type;

    // address of a register slot
    function automatic logic [4:0] reg_addr(input int idx);
        case (idx)
            CHIP_SETUP_IDX:  reg_addr = CHIP_SETUP_ADDR;
            SWITCH_SRC_IDX:  reg_addr = SWITCH_SOURCE_ADDR;
            FIRST_MODE_IDX:  reg_addr = FIRST_MODE_ADDR;
            default:         reg_addr = SECOND_MODE_ADDR;
        endcase
    endfunction : reg_addr

endpackage : rms_pkg

/* design/rms_radio_mode_select.sv */
// Function
// - two main modes, each with its own register; exactly one active
// - each main mode selects one of four sub-modes
// - host switches modes by register writes or by the select pin
// - external-select bit picks pin or chip-setup bit 0 as mode chooser
// - mode 1 takes sub-mode from bits 7..6 at address 06
// - mode 2 takes sub-mode from bits 7..6 at address 09
// - sub-mode 00 sleep, 01 standby, 10 receive, 11 transmit
`timescale 1ns/1ns
module rms_radio_mode_select (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // register access port
    input  wire logic [4:0] regAddr,
    input  wire logic       regWrEn,
    input  wire logic [7:0] regWrData,
    input  wire logic       regRdEn,
    output logic      [7:0] regRdData,
    output logic            regRdValid,
    // mode-select pin
    input  wire logic       switchIn,
    output logic            switchOut,
    output logic            switchOe,
    // operating state
    output logic            activeMode,
    output logic      [1:0] subMode,
    output logic            sleepMode,
    output logic            standbyMode,
    output logic            receiveMode,
    output logic            transmitMode
);

    // register file
    logic [7:0] regValue [rms_pkg::REG_COUNT];
    logic [7:0] readTerm [rms_pkg::REG_COUNT];
    logic [rms_pkg::REG_COUNT-1:0] regHit;

    genvar gi;
    generate
        for (gi = 0; gi < rms_pkg::REG_COUNT; gi = gi + 1) begin : g_reg
            assign regHit[gi] = (regAddr == rms_pkg::reg_addr(gi));
            rms_byte_reg u_reg (
                .clk       (clk),
                .reset     (reset),
                .writeEn   (regWrEn & regHit[gi]),
                .writeData (regWrData),
                .value     (regValue[gi])
            );
            assign readTerm[gi] = regHit[gi] ? regValue[gi] : 8'h00;
        end
    endgenerate

    // read data, unmapped addresses read zero
    logic [7:0] readMux;
    assign readMux = readTerm[0] | readTerm[1] | readTerm[2] | readTerm[3];

    // source selection
    logic extSelect;
    logic regModeSel;
    logic modeSelect;
    logic [1:0] firstSub;
    logic [1:0] secondSub;
    rms_pkg::rms_sub_type subSelect;

    assign extSelect  = regValue[rms_pkg::SWITCH_SRC_IDX][rms_pkg::EXT_SEL_BIT];
    assign regModeSel = regValue[rms_pkg::CHIP_SETUP_IDX][rms_pkg::MODE_SEL_BIT];
    assign modeSelect = extSelect ? switchIn : regModeSel;
    assign firstSub   = regValue[rms_pkg::FIRST_MODE_IDX][rms_pkg::SUB_MSB:rms_pkg::SUB_LSB];
    assign secondSub  = regValue[rms_pkg::SECOND_MODE_IDX][rms_pkg::SUB_MSB:rms_pkg::SUB_LSB];
    assign subSelect  = rms_pkg::rms_sub_type'(modeSelect ? secondSub : firstSub);

    logic sleep_next;
    logic standby_next;
    logic receive_next;
    logic transmit_next;
    always_comb begin
        sleep_next    = 1'h0;
        standby_next  = 1'h0;
        receive_next  = 1'h0;
        transmit_next = 1'h0;
        case (subSelect)
            rms_pkg::SUB_SLEEP:    sleep_next    = 1'h1;
            rms_pkg::SUB_STANDBY:  standby_next  = 1'h1;
            rms_pkg::SUB_RECEIVE:  receive_next  = 1'h1;
            rms_pkg::SUB_TRANSMIT: transmit_next = 1'h1;
            default:               sleep_next    = 1'h1;
        endcase
    end

    // pin driven when external select off
    logic pinOe_next;
    logic pinOut_next;
    assign pinOe_next  = ~extSelect;
    assign pinOut_next = ~extSelect & transmit_next;

    // mode and read answer next values
    logic       mode_next;
    logic [1:0] sub_next;
    logic [7:0] rdData_next;
    logic       rdValid_next;
    assign mode_next    = modeSelect;
    assign sub_next     = subSelect;
    assign rdData_next  = regRdEn ? readMux : 8'h00;
    assign rdValid_next = regRdEn;

    // output registers
    logic       mode_reg;
    logic [1:0] sub_reg;
    logic       sleep_reg;
    logic       standby_reg;
    logic       receive_reg;
    logic       transmit_reg;
    logic       pinOut_reg;
    logic       pinOe_reg;
    logic [7:0] rdData_reg;
    logic       rdValid_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            mode_reg <= rms_pkg::MODE_RESET;
        end else begin
            mode_reg <= mode_next;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sub_reg <= rms_pkg::SUB_SLEEP;
        end else begin
            sub_reg <= sub_next;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sleep_reg <= rms_pkg::SLEEP_RESET;
        end else begin
            sleep_reg <= sleep_next;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            standby_reg <= rms_pkg::FLAG_RESET;
        end else begin
            standby_reg <= standby_next;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            receive_reg <= rms_pkg::FLAG_RESET;
        end else begin
            receive_reg <= receive_next;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            transmit_reg <= rms_pkg::FLAG_RESET;
        end else begin
            transmit_reg <= transmit_next;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pinOut_reg <= rms_pkg::PIN_OUT_RESET;
        end else begin
            pinOut_reg <= pinOut_next;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pinOe_reg <= rms_pkg::PIN_OE_RESET;
        end else begin
            pinOe_reg <= pinOe_next;
        end
    end

    // read data answer
    always_ff @(posedge clk) begin
        if (reset) begin
            rdData_reg <= rms_pkg::RD_DATA_RESET;
        end else begin
            rdData_reg <= rdData_next;
        end
    end

    // read valid answer
    always_ff @(posedge clk) begin
        if (reset) begin
            rdValid_reg <= rms_pkg::RD_VALID_RESET;
        end else begin
            rdValid_reg <= rdValid_next;
        end
    end

    // outputs straight from the flops
    assign activeMode   = mode_reg;
    assign subMode      = sub_reg;
    assign sleepMode    = sleep_reg;
    assign standbyMode  = standby_reg;
    assign receiveMode  = receive_reg;
    assign transmitMode = transmit_reg;
    assign switchOut    = pinOut_reg;
    assign switchOe     = pinOe_reg;
    assign regRdData    = rdData_reg;
    assign regRdValid   = rdValid_reg;

endmodule : rms_radio_mode_select

/* sim/rms_host_pin.sv */
`timescale 1ns/1ns
module rms_host_pin (
    // device side
    input  wire logic switchOe,
    input  wire logic switchOut,
    // host side
    input  wire logic hostLevel,
    output logic      pinLevel
);
    assign pinLevel = switchOe ? switchOut : hostLevel;
endmodule : rms_host_pin

/* sim/rms_mode_props.sv */
`timescale 1ns/1ns
module rms_mode_props (
    input wire logic       clk, reset, regWrEn, regRdEn, regRdValid,
    input wire logic       switchIn, switchOut, switchOe, activeMode,
    input wire logic       sleepMode, standbyMode, receiveMode, transmitMode,
    input wire logic [4:0] regAddr,
    input wire logic [7:0] regWrData, regRdData,
    input wire logic [1:0] subMode
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    decode_a: assert property ({transmitMode, receiveMode, standbyMode, sleepMode}
        == 4'h1 << subMode) else $error("bad decode");
    pin_out_a: assert property (switchOut == (transmitMode && switchOe))
        else $error("bad pin drive");
    ext_sel_a: assert property (regWrEn && regAddr == 5'h02 |=> ##1
        switchOe == !$past(regWrData[3], 2)) else $error("bad pin enable");
    pin_mode_a: assert property (!switchOe ##1 !switchOe |->
        activeMode == $past(switchIn)) else $error("pin not followed");
    mode1_sub_a: assert property (regWrEn && regAddr == 5'h06 ##1
        (!regWrEn && !activeMode) [*2] |-> subMode == $past(regWrData[7:6], 2))
        else $error("bad mode 1 state");
    mode2_sub_a: assert property (regWrEn && regAddr == 5'h09 ##1
        (!regWrEn && activeMode) [*2] |-> subMode == $past(regWrData[7:6], 2))
        else $error("bad mode 2 state");
    rd_valid_a: assert property (regRdValid == ($past(regRdEn) && !$past(reset)))
        else $error("bad read valid");
    unmapped_a: assert property (regRdEn && !(regAddr inside {5'h00, 5'h02, 5'h06,
        5'h09}) |=> regRdData == 8'h00) else $error("unmapped read");
endmodule : rms_mode_props
bind rms_radio_mode_select rms_mode_props u_props (
    .clk          (clk),
    .reset        (reset),
    .regWrEn      (regWrEn),
    .regRdEn      (regRdEn),
    .regRdValid   (regRdValid),
    .switchIn     (switchIn),
    .switchOut    (switchOut),
    .switchOe     (switchOe),
    .activeMode   (activeMode),
    .sleepMode    (sleepMode),
    .standbyMode  (standbyMode),
    .receiveMode  (receiveMode),
    .transmitMode (transmitMode),
    .regAddr      (regAddr),
    .regWrData    (regWrData),
    .regRdData    (regRdData),
    .subMode      (subMode)
);

/* sim/tb_radio_mode_select.sv */
`timescale 1ns/1ns
module tb_radio_mode_select;
    logic       clk = 1'b0, reset = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0, hostLevel = 1'b0;
    logic [4:0] regAddr = 5'h00;
    logic [7:0] regWrData = 8'h00, regRdData, d;
    logic       regRdValid, switchIn, switchOut, switchOe, activeMode;
    logic       sleepMode, standbyMode, receiveMode, transmitMode;
    logic [1:0] subMode;
    logic [8:0] expQ[$];
    int         error_cnt = 0, comparisons = 0, cycles = 0;
    always #20 clk = ~clk;
    rms_radio_mode_select u_dut (
        .clk          (clk),
        .reset        (reset),
        .regAddr      (regAddr),
        .regWrEn      (regWrEn),
        .regWrData    (regWrData),
        .regRdEn      (regRdEn),
        .regRdData    (regRdData),
        .regRdValid   (regRdValid),
        .switchIn     (switchIn),
        .switchOut    (switchOut),
        .switchOe     (switchOe),
        .activeMode   (activeMode),
        .subMode      (subMode),
        .sleepMode    (sleepMode),
        .standbyMode  (standbyMode),
        .receiveMode  (receiveMode),
        .transmitMode (transmitMode)
    );
    rms_host_pin u_host (.switchOe(switchOe), .switchOut(switchOut), .hostLevel(hostLevel),
        .pinLevel(switchIn));
    task automatic conclude();
        if (expQ.size() != 0) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, expQ.size(), 0);
        end
        $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    task automatic cmp(input logic [8:0] g, input logic [8:0] e);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        regAddr = a;
        regWrData = v;
        regWrEn = 1'b1;
        @(negedge clk) regWrEn = 1'b0;
        @(negedge clk);
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        regAddr = a;
        regRdEn = 1'b1;
        expQ.push_back({1'b0, e});
        @(negedge clk) regRdEn = 1'b0;
        @(negedge clk);
    endtask : rd
    task automatic chk(input logic m, input logic [1:0] s, input logic oe);
        repeat (2) @(negedge clk);
        cmp({activeMode, subMode, transmitMode, receiveMode, standbyMode, sleepMode, switchOut,
            switchOe}, {m, s, 4'h1 << s, oe && s == 2'h3, oe});
    endtask : chk
    always @(negedge clk) if (regRdValid === 1'b1) cmp({1'b0, regRdData}, expQ.pop_front());
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        void'($urandom(32'h04EA));
        repeat (12) @(negedge clk);
        reset = 1'b0;
        chk(1'b0, 2'h0, 1'b1);
        foreach (d[i]) rd(5'(i * 3), 8'h00);
        for (int s = 0; s < 4; s++) begin
            d = {s[1:0], 6'($urandom)};
            wr(5'h09, ~d);
            rd(5'h09, ~d);
            wr(5'h06, d);
            chk(1'b0, s[1:0], 1'b1);
            wr(5'h00, 8'h01);
            chk(1'b1, ~s[1:0], 1'b1);
            wr(5'h09, d);
            chk(1'b1, s[1:0], 1'b1);
            wr(5'h00, 8'h00);
        end
        wr(5'h02, 8'h08);
        chk(1'b0, 2'h3, 1'b0);
        hostLevel = 1'b1;
        wr(5'h09, 8'h40);
        chk(1'b1, 2'h1, 1'b0);
        hostLevel = 1'b0;
        wr(5'h00, 8'h01);
        chk(1'b0, 2'h3, 1'b0);
        rd(5'h02, 8'h08);
        wr(5'h01, 8'hFF);
        rd(5'h01, 8'h00);
        wr(5'h02, 8'h00);
        chk(1'b1, 2'h1, 1'b1);
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        chk(1'b0, 2'h0, 1'b1);
        rd(5'h00, 8'h00);
        rd(5'h06, 8'h00);
        rd(5'h09, 8'h00);
        conclude();
    end
endmodule : tb_radio_mode_select
